/* core/lbcd_crc8.sv */
// one byte step of the packet checksum, polynomial x^8+x^2+x+1
`timescale 1ns/1ps
`default_nettype none
module lbcd_crc8
   import lbcd_pkg::*;
(
   input wire logic [7:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [7:0] crc_out
);
   always_comb begin
      logic [7:0] c;
      c = crc_in ^ data_in;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ LBCD_CRC_POLY) : {c[6:0], 1'b0};
      end
      crc_out = c;
   end
endmodule
`default_nettype wire

/* core/lbcd_decoder.sv */
// command decoder of the eight channel led bypass switch on its serial port
`timescale 1ns/1ps
`default_nettype none
module lbcd_decoder
   import lbcd_pkg::*;
#(
   parameter int NCH = LBCD_NCH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [3:0] addr_select_pin,
   input wire logic alert_active,
   input wire logic [NCH-1:0] fade_done_flag,
   output logic [NCH-1:0][15:0] channel_config,
   output logic [7:0] all_channel_state,
   output logic [2:0] channel_pointer,
   output logic [NCH-1:0] open_threshold_sel,
   output logic [NCH-1:0] short_threshold_sel,
   output logic [NCH-1:0] async_force_en,
   output logic [NCH-1:0] async_force_level,
   output logic [NCH-1:0] fade_bypass,
   output logic [NCH-1:0][15:0] fade_step_periods,
   output logic dim_counter_restart,
   output logic pwm_source_clock_restore
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_ACKH, ST_TX, ST_TXACK
   } lbcd_state_type;

   // =====================================================
   // pin sampling and bus conditions
   logic scl_s, sda_s, scl_d_reg, sda_d_reg;
   logic [3:0] addr_s;

   lbcd_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in({scl_in, sda_in}),
      .sync_out({scl_s, sda_s})
   );

   lbcd_sync #(.WIDTH(4), .INIT(4'h0)) u_addr_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in(addr_select_pin),
      .sync_out(addr_s)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // =====================================================
   // state
   lbcd_state_type state_reg;
   lbcd_mode_type mode_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg, tx_reg, crc_reg, cmd_reg, dim_reg;
   logic [2:0] byte_idx_reg;
   logic ack_reg, oe_reg;
   lbcd_pend_type sc_pend_reg;
   logic ac_pend_reg;
   logic [7:0] ac_data_reg;
   logic [15:0] cfg_reg [NCH];
   logic [7:0] acs_reg;
   logic [2:0] ptr_reg;
   logic restart_reg;

   // =====================================================
   // byte decode
   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
   wire byte_done = (state_reg == ST_RX) && scl_rise &&
      (bit_cnt_reg == LBCD_BITS_PER_BYTE - 4'h1);
   // channel address from prefix and pins
   wire [7:0] sc_addr_w = {LBCD_SC_PREFIX, addr_s, 1'b0};
   wire [7:0] sc_addr_r = {LBCD_SC_PREFIX, addr_s, 1'b1};
   wire [7:0] ac_addr_w = {LBCD_AC_PREFIX, addr_s, 1'b0};
   wire is_addr = byte_idx_reg == 3'h0;
   wire cmd_long = cmd_reg[LBCD_CMD_LONG_BIT];
   // short ends at byte 2, long at byte 3
   wire sc_pec = (mode_reg == LBCD_M_SC_W) &&
      ((byte_idx_reg == 3'h2 && !cmd_long) ||
       (byte_idx_reg == 3'h3 && cmd_long));
   wire sc_data = (mode_reg == LBCD_M_SC_W) &&
      (byte_idx_reg == 3'h1 || (byte_idx_reg == 3'h2 && cmd_long));
   wire ac_pec = (mode_reg == LBCD_M_AC_W) && (byte_idx_reg == 3'h2);
   wire ac_data = (mode_reg == LBCD_M_AC_W) && (byte_idx_reg == 3'h1);
   wire pec_ok = (sc_pec || ac_pec) && (rx_byte == crc_reg);
   wire [2:0] cmd_ch = cmd_reg[LBCD_CMD_CH_HI:LBCD_CMD_CH_LO];

   // broadcast read only claimed while alerting
   wire addr_hit = (rx_byte == sc_addr_w) || (rx_byte == sc_addr_r) ||
      (rx_byte == ac_addr_w) || (rx_byte == LBCD_BC_WRITE) ||
      (rx_byte == LBCD_BC_READ && alert_active);
   wire [2:0] mode_code =
      (rx_byte == sc_addr_w) ? 3'(LBCD_M_SC_W) :
      (rx_byte == sc_addr_r) ? 3'(LBCD_M_SC_R) :
      (rx_byte == ac_addr_w) ? 3'(LBCD_M_AC_W) :
      (rx_byte == LBCD_BC_WRITE) ? 3'(LBCD_M_BC_W) :
      (rx_byte == LBCD_BC_READ) ? 3'(LBCD_M_BC_R) : 3'(LBCD_M_NONE);
   wire byte_ack = is_addr ? addr_hit : (sc_data || ac_data || pec_ok);

   // status byte, fade done from the fade engine
   // fade done is read only, never stored
   wire [15:0] ptr_cfg = cfg_reg[ptr_reg];
   wire [7:0] status_byte = {ptr_cfg[LBCD_OPEN_BIT:LBCD_FADE_LO],
      fade_done_flag[ptr_reg], ptr_cfg[LBCD_LEVEL_BIT:LBCD_ENABLE_BIT]};
   // alert answer with the all-channel address
   wire [7:0] alert_byte = {LBCD_AC_PREFIX, addr_s, 1'b1};
   wire [7:0] tx_first = (mode_reg == LBCD_M_BC_R) ? alert_byte
      : status_byte;
   wire [7:0] tx_later = (byte_idx_reg == 3'h0) ? ptr_cfg[LBCD_DIM_HI:0]
      : crc_reg;
   wire tx_more = (mode_reg == LBCD_M_SC_R) &&
      (byte_idx_reg < 3'(LBCD_SC_READ_BYTES - 1));
   wire [7:0] crc_rx_next, crc_tx_first, crc_tx_later;

   // running checksum from zero, address included
   lbcd_crc8 u_crc_rx (
      .crc_in(crc_reg),
      .data_in(rx_byte),
      .crc_out(crc_rx_next)
   );

   lbcd_crc8 u_crc_tx0 (
      .crc_in(crc_reg),
      .data_in(tx_first),
      .crc_out(crc_tx_first)
   );

   lbcd_crc8 u_crc_tx1 (
      .crc_in(crc_reg),
      .data_in(tx_later),
      .crc_out(crc_tx_later)
   );

   // =====================================================
   // serial engine
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         mode_reg <= LBCD_M_NONE;
         bit_cnt_reg <= 4'h0;
         byte_idx_reg <= 3'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         crc_reg <= 8'h00;
         cmd_reg <= 8'h00;
         dim_reg <= 8'h00;
         ack_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (start_cond) begin
         // repeated start also lands here
         state_reg <= ST_RX;
         mode_reg <= LBCD_M_NONE;
         bit_cnt_reg <= 4'h0;
         byte_idx_reg <= 3'h0;
         crc_reg <= 8'h00;
         oe_reg <= 1'b0;
      end else if (stop_cond) begin
         state_reg <= ST_IDLE;
         oe_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               oe_reg <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_reg <= rx_byte;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               if (byte_done) begin
                  state_reg <= ST_ACK;
                  ack_reg <= byte_ack;
                  crc_reg <= crc_rx_next;
                  if (is_addr) begin
                     mode_reg <= lbcd_mode_type'(mode_code);
                  end
                  if (sc_data || ac_data) begin
                     if (byte_idx_reg == 3'h1) begin
                        cmd_reg <= rx_byte;
                     end else begin
                        dim_reg <= rx_byte;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  oe_reg <= ack_reg;
                  state_reg <= ST_ACKH;
               end
            end
            ST_ACKH: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (!ack_reg || mode_reg == LBCD_M_BC_W) begin
                     // unclaimed or finished: wait for start or stop
                     state_reg <= ST_IDLE;
                     oe_reg <= 1'b0;
                  end else if (mode_reg == LBCD_M_SC_R ||
                               mode_reg == LBCD_M_BC_R) begin
                     state_reg <= ST_TX;
                     tx_reg <= tx_first;
                     oe_reg <= ~tx_first[7];
                     crc_reg <= crc_tx_first;
                  end else begin
                     state_reg <= ST_RX;
                     oe_reg <= 1'b0;
                     byte_idx_reg <= byte_idx_reg + 3'h1;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               if (scl_fall) begin
                  if (bit_cnt_reg == LBCD_BITS_PER_BYTE) begin
                     state_reg <= ST_TXACK;
                     oe_reg <= 1'b0;
                  end else begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     oe_reg <= ~tx_reg[6];
                  end
               end
            end
            ST_TXACK: begin
               // master acknowledge is optional and not examined
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (tx_more) begin
                     byte_idx_reg <= byte_idx_reg + 3'h1;
                     tx_reg <= tx_later;
                     oe_reg <= ~tx_later[7];
                     crc_reg <= crc_tx_later;
                     state_reg <= ST_TX;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // =====================================================
   // holding latches and configuration registers
   wire pec_take = byte_done && pec_ok;
   wire bc_take = byte_done && is_addr && (rx_byte == LBCD_BC_WRITE);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sc_pend_reg <= '0;
         ac_pend_reg <= 1'b0;
         ac_data_reg <= 8'h00;
         ptr_reg <= 3'h0;
         acs_reg <= 8'h00;
         restart_reg <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            cfg_reg[i] <= LBCD_CFG_RESET;
         end
      end else begin
         // broadcast write only pulses, no register changes
         restart_reg <= bc_take;
         if (pec_take && sc_pec) begin
            sc_pend_reg <= '{valid: 1'b1, cmd: cmd_reg, dim: dim_reg};
            // pointer follows last validated channel write
            ptr_reg <= cmd_ch;
            // thresholds take effect at checksum ack
            if (!cmd_long) begin
               cfg_reg[cmd_ch][LBCD_OPEN_BIT] <=
                  cmd_reg[LBCD_CMD_OPEN_BIT];
               cfg_reg[cmd_ch][LBCD_SHORT_BIT] <=
                  cmd_reg[LBCD_CMD_SHORT_BIT];
            end
         end
         if (pec_take && ac_pec) begin
            ac_pend_reg <= 1'b1;
            ac_data_reg <= cmd_reg;
         end
         if (stop_cond) begin
            sc_pend_reg.valid <= 1'b0;
            ac_pend_reg <= 1'b0;
            if (ac_pend_reg) begin
               acs_reg <= ac_data_reg;
               // all channels switch in one update
               for (int i = 0; i < NCH; i++) begin
                  cfg_reg[i][LBCD_DIM_HI:0] <= {8{ac_data_reg[i]}};
               end
            end
            // only the addressed channel is touched
            if (sc_pend_reg.valid) begin
               if (sc_pend_reg.cmd[LBCD_CMD_LONG_BIT]) begin
                  // long write loads fade, enable, dim
                  cfg_reg[sc_pend_reg.cmd[LBCD_CMD_CH_HI:LBCD_CMD_CH_LO]]
                     [LBCD_FADE_HI:LBCD_FADE_LO] <=
                     sc_pend_reg.cmd[LBCD_CMD_FADE_HI:LBCD_CMD_FADE_LO];
                  cfg_reg[sc_pend_reg.cmd[LBCD_CMD_CH_HI:LBCD_CMD_CH_LO]]
                     [LBCD_ENABLE_BIT] <=
                     sc_pend_reg.cmd[LBCD_CMD_ENABLE_BIT];
                  cfg_reg[sc_pend_reg.cmd[LBCD_CMD_CH_HI:LBCD_CMD_CH_LO]]
                     [LBCD_DIM_HI:0] <= sc_pend_reg.dim;
               end else begin
                  cfg_reg[sc_pend_reg.cmd[LBCD_CMD_CH_HI:LBCD_CMD_CH_LO]]
                     [LBCD_LEVEL_BIT:LBCD_ENABLE_BIT] <=
                     sc_pend_reg.cmd[LBCD_CMD_LEVEL_BIT:LBCD_CMD_ENABLE_BIT];
                  // async short write overwrites dim value
                  if (sc_pend_reg.cmd[LBCD_CMD_ENABLE_BIT]) begin
                     cfg_reg[sc_pend_reg.cmd[LBCD_CMD_CH_HI:LBCD_CMD_CH_LO]]
                        [LBCD_DIM_HI:0] <=
                        {8{sc_pend_reg.cmd[LBCD_CMD_LEVEL_BIT]}};
                  end
               end
            end
         end
      end
   end

   // =====================================================
   // registered channel controls
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         all_channel_state <= 8'h00;
         channel_pointer <= 3'h0;
         dim_counter_restart <= 1'b0;
         pwm_source_clock_restore <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            channel_config[i] <= LBCD_CFG_RESET;
            open_threshold_sel[i] <= LBCD_CFG_RESET[LBCD_OPEN_BIT];
            short_threshold_sel[i] <= LBCD_CFG_RESET[LBCD_SHORT_BIT];
            async_force_en[i] <= 1'b0;
            async_force_level[i] <= 1'b0;
            fade_bypass[i] <= 1'b1;
            fade_step_periods[i] <= 16'h0000;
         end
      end else begin
         // open drain: only ever pulls low
         sda_oe <= oe_reg;
         sda_out <= 1'b0;
         all_channel_state <= acs_reg;
         channel_pointer <= ptr_reg;
         dim_counter_restart <= restart_reg;
         pwm_source_clock_restore <= restart_reg;
         for (int i = 0; i < NCH; i++) begin
            channel_config[i] <= cfg_reg[i];
            // open threshold choice to fault comparator
            open_threshold_sel[i] <= cfg_reg[i][LBCD_OPEN_BIT];
            short_threshold_sel[i] <= cfg_reg[i][LBCD_SHORT_BIT];
            async_force_en[i] <= cfg_reg[i][LBCD_ENABLE_BIT];
            async_force_level[i] <= cfg_reg[i][LBCD_LEVEL_BIT];
            fade_bypass[i] <= cfg_reg[i][LBCD_FADE_HI:LBCD_FADE_LO] == 3'h0;
            // code to multiplier, step in pwm periods
            fade_step_periods[i] <= 16'(lbcd_fade_mult(
               cfg_reg[i][LBCD_FADE_HI:LBCD_FADE_LO]) *
               LBCD_PWM_CYCLE_PERIODS);
         end
      end
   end
endmodule
`default_nettype wire

/* core/lbcd_pkg.sv */
// shared constants, types and helpers of the led bypass command decoder
package lbcd_pkg;

   // =====================================================
   // bus addresses and formats
   localparam logic [2:0] LBCD_SC_PREFIX = 3'h5;
   localparam logic [2:0] LBCD_AC_PREFIX = 3'h2;
   localparam logic [7:0] LBCD_BC_WRITE = 8'h18;
   localparam logic [7:0] LBCD_BC_READ = 8'h19;
   localparam int LBCD_NCH = 8;
   localparam int LBCD_SC_READ_BYTES = 3;

   // =====================================================
   // channel config field positions
   localparam int LBCD_OPEN_BIT = 15;
   localparam int LBCD_SHORT_BIT = 14;
   localparam int LBCD_FADE_HI = 13;
   localparam int LBCD_FADE_LO = 11;
   localparam int LBCD_LEVEL_BIT = 9;
   localparam int LBCD_ENABLE_BIT = 8;
   localparam int LBCD_DIM_HI = 7;
   localparam logic [15:0] LBCD_CFG_RESET = 16'h8000;

   // =====================================================
   // command byte field positions
   localparam int LBCD_CMD_LONG_BIT = 7;
   localparam int LBCD_CMD_CH_HI = 6;
   localparam int LBCD_CMD_CH_LO = 4;
   localparam int LBCD_CMD_OPEN_BIT = 3;
   localparam int LBCD_CMD_SHORT_BIT = 2;
   localparam int LBCD_CMD_LEVEL_BIT = 1;
   localparam int LBCD_CMD_ENABLE_BIT = 0;
   localparam int LBCD_CMD_FADE_HI = 3;
   localparam int LBCD_CMD_FADE_LO = 1;

   // =====================================================
   // timing and crc
   localparam logic [15:0] LBCD_PWM_CYCLE_PERIODS = 16'h0800;
   localparam logic [7:0] LBCD_CRC_POLY = 8'h07;
   localparam logic [3:0] LBCD_BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {
      LBCD_M_NONE, LBCD_M_SC_W, LBCD_M_SC_R, LBCD_M_AC_W, LBCD_M_BC_W,
      LBCD_M_BC_R
   } lbcd_mode_type;

   typedef struct packed {
      logic valid;
      logic [7:0] cmd;
      logic [7:0] dim;
   } lbcd_pend_type;

   // multiplier per fade code, ascending
   function automatic logic [4:0] lbcd_fade_mult(input logic [2:0] code);
      logic [4:0] m;
      m = 5'h00;
      unique case (code)
         3'h0: m = 5'h00;
         3'h1: m = 5'h01;
         3'h2: m = 5'h02;
         3'h3: m = 5'h04;
         3'h4: m = 5'h08;
         3'h5: m = 5'h10;
         3'h6: m = 5'h18;
         3'h7: m = 5'h1F;
      endcase
      return m;
   endfunction

endpackage

/* core/lbcd_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module lbcd_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= INIT;
         sync_out <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

/* tb/lbcd_decoder_asserts.sv */
// checker of the decoder's derived outputs and commit timing
`timescale 1ns/1ps
`default_nettype none
module lbcd_decoder_asserts
   import lbcd_pkg::*;
#(
   parameter int NCH = LBCD_NCH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic [NCH-1:0][15:0] channel_config,
   input wire logic [NCH-1:0] open_threshold_sel,
   input wire logic [NCH-1:0] short_threshold_sel,
   input wire logic [NCH-1:0] async_force_en,
   input wire logic [NCH-1:0] fade_bypass,
   input wire logic [NCH-1:0][15:0] fade_step_periods,
   input wire logic dim_counter_restart,
   input wire logic pwm_source_clock_restore
);
   // ==========
   // expected copies, own multiplier table
   localparam logic [4:0] MT [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08,
      5'h10, 5'h18, 5'h1F};
   logic [NCH-1:0] c_open, c_short, c_en, c_zero;
   logic [NCH-1:0][15:0] c_step;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         c_open[i] = channel_config[i][LBCD_OPEN_BIT];
         c_short[i] = channel_config[i][LBCD_SHORT_BIT];
         c_en[i] = channel_config[i][LBCD_ENABLE_BIT];
         c_zero[i] = channel_config[i][13:11] == 3'h0;
         c_step[i] = {MT[channel_config[i][13:11]], 11'h000};
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // config and derived outputs are registered together, so no lag
   open_copy_a: assert property (open_threshold_sel == c_open)
      else $error("open select does not follow config");
   short_copy_a: assert property (short_threshold_sel == c_short)
      else $error("short select does not follow config");
   force_copy_a: assert property (async_force_en == c_en)
      else $error("force enable does not follow config");
   fade_bypass_a: assert property (fade_bypass == c_zero)
      else $error("fade bypass wrong for code");
   step_length_a: assert property (fade_step_periods == c_step)
      else $error("fade step length wrong");
   restart_pair_a: assert property (
      dim_counter_restart == pwm_source_clock_restore)
      else $error("restart and clock restore differ");
   restart_pulse_a: assert property (
      dim_counter_restart |=> !dim_counter_restart)
      else $error("restart pulse longer than one clock");
   commit_idle_a: assert property ($changed(channel_config) |-> scl_in)
      else $error("config changed while bus clock low");
endmodule
`default_nettype wire

/* tb/lbcd_decoder_tb.sv */
// self-checking bench of the command decoder
`timescale 1ns/1ps
`default_nettype none
module lbcd_decoder_tb
   import lbcd_pkg::*;
;
   localparam int NCH = LBCD_NCH;
   localparam logic [3:0] PINS = 4'hB;
   localparam logic [7:0] SCW = {LBCD_SC_PREFIX, PINS, 1'b0};
   localparam logic [7:0] SCR = {LBCD_SC_PREFIX, PINS, 1'b1};
   localparam logic [4:0] MT [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08,
      5'h10, 5'h18, 5'h1F};
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] dim;
      logic [15:0] exp;
   } lbcd_row_type;
   logic clk, resetn, alert_active, sda_out, sda_oe, scl, sda_m;
   logic rst_pulse, clk_restore;
   logic [NCH-1:0] fade_done_flag, ots, sts, afe, afl, fbp;
   logic [NCH-1:0][15:0] cfg, fsp, mdl;
   logic [7:0] acs;
   logic [2:0] ptr;
   int n_errors = 0, cmp_count = 0, cyc = 0, pulses = 0;
   wire logic sda = sda_m & ~sda_oe;

   lbcd_decoder #(.NCH(NCH)) DUT (.clk(clk), .resetn(resetn), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin(PINS), .alert_active(alert_active),
      .fade_done_flag(fade_done_flag), .channel_config(cfg),
      .all_channel_state(acs), .channel_pointer(ptr),
      .open_threshold_sel(ots), .short_threshold_sel(sts),
      .async_force_en(afe), .async_force_level(afl), .fade_bypass(fbp),
      .fade_step_periods(fsp), .dim_counter_restart(rst_pulse),
      .pwm_source_clock_restore(clk_restore));
   lbcd_i2c_master m (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_wire(sda));

   // ==========
   // helpers
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rst_pulse === 1'b1) pulses <= pulses + 1;
      if (cyc == 60000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic check(input string nm, input logic [127:0] e, g);
      cmp_count++;
      if (e !== g) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c, d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
      return x;
   endfunction
   task automatic wr(input logic [7:0] a, d0, d1, input logic two, bad,
      output logic kp);
      logic [7:0] c;
      logic k;
      c = crc8(crc8(8'h00, a), d0);
      m.start();
      m.wbyte(a, k);
      m.wbyte(d0, k);
      if (two) begin
         c = crc8(c, d1);
         m.wbyte(d1, k);
      end
      m.wbyte(c ^ {7'h00, bad}, kp);
   endtask
   task automatic rd(input logic [15:0] e, input logic [2:0] ch);
      logic [7:0] st, dm, pc, se;
      logic k;
      se = {e[15:11], fade_done_flag[ch], e[9:8]};
      m.start();
      m.wbyte(SCR, k);
      m.rbyte(st);
      m.rbyte(dm);
      m.rbyte(pc);
      m.stop();
      check("read ack", 1'b1, k);
      check("status", se, st);
      check("read dim", e[7:0], dm);
      check("read pec", crc8(crc8(crc8(8'h00, SCR), se), dm), pc);
   endtask

   // ==========
   // main sequence
   initial begin
      lbcd_row_type rows [5];
      logic kp, k;
      logic [7:0] v;
      logic [2:0] ch;
      rows = '{'{8'h05, 8'h00, 16'h4100}, '{8'hBE, 8'h5A, 16'hB85A},
         '{8'h7B, 8'h00, 16'h83FF}, '{8'hF8, 8'h10, 16'hA210},
         '{8'h22, 8'h00, 16'h0200}};
      resetn = 1'b0;
      alert_active = 1'b0;
      fade_done_flag = 8'h5A;
      mdl = {NCH{16'h8000}};
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (12) @(posedge clk);
      check("cfg reset", mdl, cfg);
      check("ptr reset", 3'h0, ptr);
      rd(16'h8000, 3'h0);
      // thresholds go first, one channel per write
      foreach (rows[i]) begin
         ch = rows[i].cmd[6:4];
         mdl[ch] = rows[i].exp;
         wr(SCW, rows[i].cmd, rows[i].dim, rows[i].cmd[7], 1'b0, kp);
         check("pec ack", 1'b1, kp);
         check("early thr", mdl[ch][15:14], cfg[ch][15:14]);
         m.stop();
         check("config", mdl, cfg);
         check("force", mdl[ch][9:8], {afl[ch], afe[ch]});
         check("pointer", ch, ptr);
         rd(mdl[ch], ch);
      end
      for (int f = 0; f < 8; f++) begin
         wr(SCW, {4'h9, f[2:0], 1'b0}, 8'h40, 1'b1, 1'b0, kp);
         m.stop();
         check("step", {MT[f], 11'h000}, fsp[1]);
         check("bypass", f == 0, fbp[1]);
      end
      mdl[1] = 16'hB840;
      wr(SCW, 8'h50, 8'h00, 1'b0, 1'b1, kp);
      check("bad pec", 1'b0, kp);
      m.stop();
      check("cfg kept", mdl, cfg);
      check("ptr kept", 3'h1, ptr);
      m.start();
      m.wbyte(LBCD_BC_WRITE, k);
      m.stop();
      check("bcast ack", 1'b1, k);
      check("restarts", 32'h1, pulses);
      check("bcast cfg", mdl, cfg);
      for (int al = 0; al < 2; al++) begin
         alert_active <= al[0];
         m.start();
         m.wbyte(LBCD_BC_READ, k);
         if (k) m.rbyte(v);
         m.stop();
         check("alert ack", al[0], k);
      end
      check("alert reply", {3'h2, PINS, 1'b1}, v);
      m.start();
      m.wbyte({LBCD_SC_PREFIX, ~PINS, 1'b0}, k);
      m.stop();
      check("other addr", 1'b0, k);
      // each all-channel write turns on one more channel
      v = 8'h00;
      for (int b = 0; b < NCH; b += 2) begin
         v[b] = 1'b1;
         wr({LBCD_AC_PREFIX, PINS, 1'b0}, v, 8'h00, 1'b0, 1'b0, kp);
         m.stop();
         check("all ack", 1'b1, kp);
         check("all state", v, acs);
         for (int c = 0; c < NCH; c++) begin
            check("all dim", {8{v[c]}}, cfg[c][7:0]);
         end
      end
      // mid-run reset brings back defaults and channel pointer 0
      resetn <= 1'b0;
      @(posedge clk);
      check("rst cfg", {NCH{16'h8000}}, cfg);
      check("rst sda", 2'h0, {sda_out, sda_oe});
      resetn <= 1'b1;
      repeat (12) @(posedge clk);
      rd(16'h8000, 3'h0);
      finish_test();
   end
endmodule

bind lbcd_decoder lbcd_decoder_asserts #(.NCH(NCH)) chk (.clk(clk),
   .resetn(resetn), .scl_in(scl_in), .channel_config(channel_config),
   .open_threshold_sel(open_threshold_sel),
   .short_threshold_sel(short_threshold_sel),
   .async_force_en(async_force_en), .fade_bypass(fade_bypass),
   .fade_step_periods(fade_step_periods),
   .dim_counter_restart(dim_counter_restart),
   .pwm_source_clock_restore(pwm_source_clock_restore));
`default_nettype wire

/* tb/lbcd_i2c_master.sv */
// bus master model driving the serial clock and data lines
`timescale 1ns/1ps
`default_nettype none
module lbcd_i2c_master (
   input wire logic clk,
   output logic scl,
   output logic sda_m,
   input wire logic sda_wire
);
   // ==========
   // bit and byte tasks, entered just after a clock edge
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // 31 clocks a bit, as near the 125 ns link period as the clock allows
   task automatic xbit(input logic b, output logic r);
      sda_m <= b;
      hold(8);
      scl <= 1'b1;
      hold(16);
      r = sda_wire;
      scl <= 1'b0;
      hold(7);
   endtask
   task automatic start;
      sda_m <= 1'b1;
      hold(8);
      scl <= 1'b1;
      hold(16);
      sda_m <= 1'b0;
      hold(16);
      scl <= 1'b0;
      hold(8);
   endtask
   task automatic stop;
      sda_m <= 1'b0;
      hold(8);
      scl <= 1'b1;
      hold(16);
      sda_m <= 1'b1;
      hold(16);
   endtask
   task automatic wbyte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(v[i], r);
      xbit(1'b1, r);
      ack = !r;
   endtask
   // read bytes are never acknowledged by this master
   task automatic rbyte(output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(1'b1, r);
         v[i] = r;
      end
      xbit(1'b1, r);
   endtask
endmodule
`default_nettype wire
